// ==== adcq_pkg.sv ====
package adcq_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] RESULT_OFS = 8'h0c;
  localparam logic [7:0] PWR_OFS = 8'h10;
  // ---------------------------------------------------------------
  // CTRL fields
  // ---------------------------------------------------------------
  localparam int MODULE_ON_BIT = 15;
  localparam int STOP_IN_IDLE_BIT = 13;
  localparam int TRIG_LSB = 5;
  localparam int AUTO_SAMPLE_BIT = 2;
  localparam int SAMPLE_BIT = 1;
  localparam int IRQ_FLAG_BIT = 0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // ---------------------------------------------------------------
  // CFG fields
  // ---------------------------------------------------------------
  localparam int DIV_LSB = 0;
  localparam int RC_SEL_BIT = 7;
  localparam int AUTO_SAMPLE_TIME_LSB = 8;
  localparam int SAMPLES_PER_INTERRUPT_LSB = 16;
  localparam int IRQ_EN_BIT = 20;
  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam int CONVERSION_IN_PROGRESS_TAD = 14;
  localparam real TAD_MIN_NS = 333.33;
  localparam real CLK_NS = 8.0;
  localparam int TAD_MIN_CYC = int'($ceil(TAD_MIN_NS / CLK_NS));
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcq_state_t;
endpackage : adcq_pkg

// ==== adcq_tad_gen.sv ====
`timescale 1ns/100ps
module adcq_tad_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic rc_sel,
  input wire logic rc_tick,
  input wire logic [5:0] divider,
  output logic tad_tick
);
  import adcq_pkg::*;
  // Instruction clock is aclk/2, so a half cycle is one aclk: period = divider+1 aclk
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  wire logic [6:0] limit = {1'b0, divider};
  wire logic sys_tick = (cnt_q >= limit);
  assign cnt_d = (!run || sys_tick) ? 7'h00 : cnt_q + 7'h01;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 7'h00;
      tad_tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tad_tick <= run && (rc_sel ? rc_tick : sys_tick);
    end
  end
endmodule : adcq_tad_gen

// ==== adcq_top.sv ====
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module adcq_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  input wire logic rc_tick,
  input wire logic [11:0] sar_data,
  output logic sar_clk,
  output logic result_wr,
  output logic [11:0] result_buffer,
  output logic wake_req
);
  import adcq_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] cfg_q;
  logic [11:0] res_q;
  adcq_state_t state_q;
  logic [4:0] cnt_q;
  logic [3:0] conversion_in_progress_cnt_q;
  logic powered_down_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  wire logic module_on = ctrl_q[MODULE_ON_BIT];
  wire logic stop_in_idle = ctrl_q[STOP_IN_IDLE_BIT];
  wire logic [2:0] conversion_in_progress_trigger_source = ctrl_q[TRIG_LSB +: 3];
  wire logic auto_sample_start = ctrl_q[AUTO_SAMPLE_BIT];
  wire logic sample_bit = ctrl_q[SAMPLE_BIT];
  wire logic converter_irq_flag = ctrl_q[IRQ_FLAG_BIT];
  wire logic [5:0] conversion_in_progress_clock_divider = cfg_q[DIV_LSB +: 6];
  wire logic rc_clock_select = cfg_q[RC_SEL_BIT];
  wire logic [4:0] auto_sample_time = cfg_q[AUTO_SAMPLE_TIME_LSB +: 5];
  wire logic [3:0] samples_per_interrupt = cfg_q[SAMPLES_PER_INTERRUPT_LSB +: 4];
  wire logic converter_irq_enable = cfg_q[IRQ_EN_BIT];

  // ---------------------------------------------------------------
  // Power gating
  // ---------------------------------------------------------------
  // Sleep kills the system clock path; only the RC path survives it
  wire logic sleep_halt = cpu_sleep && !rc_clock_select;
  wire logic idle_halt = cpu_idle && stop_in_idle;
  wire logic run = module_on && !powered_down_q && !sleep_halt && !idle_halt;
  wire logic tad_tick;

  adcq_tad_gen u_tad (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .rc_sel(rc_clock_select),
    .rc_tick(rc_tick),
    .divider(conversion_in_progress_clock_divider),
    .tad_tick(tad_tick)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  wire logic auto_conversion_in_progress = (conversion_in_progress_trigger_source == TRIG_AUTO);
  wire logic samp_done = auto_conversion_in_progress ? (tad_tick && cnt_q <= 5'h01) : !sample_bit;
  wire logic conversion_in_progress_done = (state_q == ST_CONVERT) && tad_tick && (cnt_q == 5'h01);
  wire logic irq_set = conversion_in_progress_done && (conversion_in_progress_cnt_q == samples_per_interrupt);
  wire logic start_samp = (state_q == ST_IDLE) && run && (auto_sample_start || sample_bit);
  wire logic in_sleep_done = conversion_in_progress_done && cpu_sleep;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
    end else if (!run) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start_samp) begin
          state_q <= ST_SAMPLE;
          cnt_q <= auto_sample_time;
        end
        ST_SAMPLE: if (samp_done) begin
          state_q <= ST_CONVERT;
          cnt_q <= 5'(CONVERSION_IN_PROGRESS_TAD);
        end else if (tad_tick && cnt_q > 5'h01) begin
          cnt_q <= cnt_q - 5'h01;
        end
        ST_CONVERT: if (tad_tick) begin
          if (cnt_q == 5'h01) begin
            state_q <= auto_sample_start ? ST_SAMPLE : ST_IDLE;
            cnt_q <= auto_sample_time;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_in_progress_cnt_q <= 4'h0;
      res_q <= 12'h000;
      powered_down_q <= 1'b0;
      sar_clk <= 1'b0;
      result_wr <= 1'b0;
      result_buffer <= 12'h000;
      wake_req <= 1'b0;
    end else begin
      // Switching the module off restarts the group, so a fresh run counts from its first conversion
      if (irq_set || !module_on) conversion_in_progress_cnt_q <= 4'h0;
      else if (conversion_in_progress_done) conversion_in_progress_cnt_q <= conversion_in_progress_cnt_q + 4'h1;
      if (conversion_in_progress_done) res_q <= sar_data;
      if (!module_on) powered_down_q <= 1'b0;
      else if (in_sleep_done && !converter_irq_enable) powered_down_q <= 1'b1;
      sar_clk <= run && (state_q == ST_CONVERT) && tad_tick;
      result_wr <= conversion_in_progress_done;
      if (conversion_in_progress_done) result_buffer <= sar_data;
      wake_req <= converter_irq_enable && (cpu_sleep || cpu_idle) && (irq_set || converter_irq_flag);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_go = aw_q && w_q && !s_axi_bvalid;
  wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire logic wr_ctrl = wr_go && (awaddr_q == CTRL_OFS);
  wire logic wr_cfg = wr_go && (awaddr_q == CFG_OFS);
  wire logic wr_ok = (awaddr_q == CTRL_OFS) || (awaddr_q == CFG_OFS);
  wire logic [31:0] ctrl_w = (ctrl_q & ~wmask) | (wdata_q & wmask);
  // Hardware set of the flag beats a software clear in the same cycle
  wire logic [31:0] ctrl_d = (wr_ctrl ? ctrl_w : ctrl_q) | {31'h0, irq_set};
  wire logic busy = (state_q == ST_CONVERT);
  wire logic [31:0] stat_w = {27'h0, powered_down_q, run, conversion_in_progress_cnt_q == 4'h0, busy, converter_irq_flag};
  wire logic rd_ok = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == CFG_OFS) || (s_axi_araddr == STAT_OFS)
                     || (s_axi_araddr == RESULT_OFS) || (s_axi_araddr == PWR_OFS);
  wire logic [31:0] rd_mux = (s_axi_araddr == CTRL_OFS) ? ctrl_q :
                             (s_axi_araddr == CFG_OFS) ? cfg_q :
                             (s_axi_araddr == STAT_OFS) ? stat_w :
                             (s_axi_araddr == RESULT_OFS) ? {20'h0, res_q} :
                             (s_axi_araddr == PWR_OFS) ? {30'h0, cpu_idle, cpu_sleep} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      cfg_q <= CFG_RST;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      ctrl_q <= ctrl_d; // registers untouched by sleep
      if (wr_cfg) cfg_q <= (cfg_q & ~wmask) | (wdata_q & wmask);
      s_axi_awready <= !aw_q && !aw_take && !s_axi_awready;
      s_axi_wready <= !w_q && !w_take && !s_axi_wready;
      if (aw_take) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions: sequencing
  // ---------------------------------------------------------------
  irq_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conversion_in_progress_done && conversion_in_progress_cnt_q != samples_per_interrupt && !wr_ctrl) |=> converter_irq_flag == $past(converter_irq_flag))
    else $error("flag set early");
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_set |=> converter_irq_flag)
    else $error("flag not set");
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (converter_irq_flag && !wr_ctrl) |=> converter_irq_flag)
    else $error("flag lost without a write");
  conversion_in_progress_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_SAMPLE && samp_done && run) |=> state_q == ST_CONVERT && cnt_q == 5'(CONVERSION_IN_PROGRESS_TAD))
    else $error("bad conversion_in_progress len");
  conversion_in_progress_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_CONVERT && tad_tick && cnt_q > 5'h01 && run) |=> state_q == ST_CONVERT && cnt_q == $past(cnt_q) - 5'h01)
    else $error("conversion count skipped");
  auto_sample_time_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_samp |=> cnt_q == $past(auto_sample_time))
    else $error("sample count not loaded");
  manual_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_SAMPLE && !auto_conversion_in_progress && sample_bit && run) |=> state_q == ST_SAMPLE)
    else $error("sampling ended without trigger");
  auto_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conversion_in_progress_done && run && auto_sample_start) |=> state_q == ST_SAMPLE)
    else $error("no auto restart");
  auto_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_IDLE && run && auto_sample_start) |=> state_q == ST_SAMPLE)
    else $error("no auto start");
  result_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    conversion_in_progress_done |=> result_wr && result_buffer == $past(sar_data))
    else $error("result not stored");
  busy_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conversion_in_progress_done && !auto_sample_start) |=> state_q == ST_IDLE)
    else $error("busy after conversion");

  // ---------------------------------------------------------------
  // Assertions: power modes
  // ---------------------------------------------------------------
  sleep_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_sleep && !rc_clock_select) |=> state_q == ST_IDLE)
    else $error("sleep no abort");
  sleep_clk_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_sleep && !rc_clock_select) |=> !sar_clk)
    else $error("clock runs in sleep");
  rc_sleep_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_sleep && rc_clock_select && run && rc_tick) |=> tad_tick)
    else $error("rc clock stopped in sleep");
  idle_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_idle && stop_in_idle) |=> state_q == ST_IDLE && !sar_clk)
    else $error("idle no abort");
  idle_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_idle && !stop_in_idle && !cpu_sleep && module_on && !powered_down_q) |-> run)
    else $error("idle stopped converter");
  off_keep_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_sleep_done && !converter_irq_enable && run && !wr_ctrl) |=> powered_down_q && module_on)
    else $error("power down");
  pd_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    powered_down_q |=> !sar_clk && state_q == ST_IDLE)
    else $error("powered down but running");
  sleep_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_set && converter_irq_enable && cpu_sleep) |=> wake_req)
    else $error("no wake");
  idle_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_set && converter_irq_enable && cpu_idle) |=> wake_req)
    else $error("no wake from idle");
  no_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !converter_irq_enable |=> !wake_req)
    else $error("wake while disabled");
  sleep_regs_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(cpu_sleep) && !wr_cfg) |=> cfg_q == $past(cfg_q))
    else $error("config lost at sleep");
endmodule : adcq_top

// ==== adcq_sar_model.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Analog core and RC oscillator stand-in
// ---------------------------------------------------------------
module adcq_sar_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic rc_tick,
  output logic [11:0] sar_data
);
  logic [1:0] div_q;
  logic [31:0] lfsr_q;
  // RC period of four cycles, deliberately slower than the aclk divider
  assign rc_tick = (div_q == 2'h3);
  // Result lines move every cycle so a late or early capture shows up
  assign sar_data = lfsr_q[11:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 2'h0;
      lfsr_q <= 32'h1234_5679;
    end else begin
      div_q <= div_q + 2'h1;
      lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    end
  end
endmodule : adcq_sar_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import adcq_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cpu_sleep, cpu_idle;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sar_clk, result_wr, wake_req, rc_tick;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, data, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [11:0] sar_data, result_buffer, last_sar;
  int err_total, check_count, n, p, k, d, s;
  adcq_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .rc_tick(rc_tick), .sar_data(sar_data), .sar_clk(sar_clk),
    .result_wr(result_wr), .result_buffer(result_buffer), .wake_req(wake_req));
  adcq_sar_model model (.aclk(aclk), .aresetn(aresetn), .rc_tick(rc_tick), .sar_data(sar_data));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic close_out();
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Edges up to the next stored result, and conversion clocks seen meanwhile
  task automatic to_result(output int cyc, output int pulses);
    cyc = 0;
    pulses = 0;
    last_sar = sar_data;
    do begin
      @(posedge aclk);
      cyc++;
      if (sar_clk) pulses++;
      if (result_wr) chk(result_buffer, last_sar);
      last_sar = sar_data;
    end while (!result_wr);
  endtask : to_result
  // Halt in mid-conversion, by sleep on the system clock or by idle with stop set
  task automatic halt(input logic slp);
    wr(CFG_OFS, 32'h0000_0101);
    wr(CTRL_OFS, slp ? 32'h0000_80e4 : 32'h0000_a0e4);
    do @(posedge aclk); while (!sar_clk);
    cpu_sleep <= slp;
    cpu_idle <= !slp;
    repeat (2) @(posedge aclk);
    n = 0;
    repeat (100) begin
      @(posedge aclk);
      if (sar_clk | result_wr) n++;
    end
    chk(n, 0);
    rd(CTRL_OFS);
    chk(data & 32'hfffe, slp ? 32'h0000_80e4 : 32'h0000_a0e4);
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b0;
    to_result(n, p);
    // A resumed conversion would finish sooner than a full fourteen periods
    chk(n >= 28, 1);
    wr(CTRL_OFS, 32'h0);
  endtask : halt
  // ---------------------------------------------------------------
  // Clock, reset, watchdog
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    #400000;
    err_total++;
    close_out();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cpu_sleep, cpu_idle} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    seed = 32'hbaee4523;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS);
    chk(data, CTRL_RST);
    rd(CFG_OFS);
    chk(data, CFG_RST);
    rd(8'h14);
    chk({data[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(STAT_OFS, 32'h1f);
    chk(resp, RESP_SLVERR);
    for (k = 0; k < 4; k++) begin
      v = rnd() & 32'h001f_1fbf;
      wr(CFG_OFS, v);
      rd(CFG_OFS);
      chk(data, v);
    end
    for (k = 0; k < 4; k++) begin
      d = int'(rnd() % 32'd4);
      s = int'(rnd() % 32'd3) + 1;
      wr(CFG_OFS, 32'h0011_0000 | 32'(d) | (32'(s) << 8));
      wr(CTRL_OFS, 32'h0000_80e4);
      to_result(n, p);
      to_result(n, p);
      chk(n, (s + CONVERSION_IN_PROGRESS_TAD) * (d + 1));
      chk(p, CONVERSION_IN_PROGRESS_TAD);
      wr(CTRL_OFS, 32'h0);
    end
    // Manual trigger: sampling lasts until software clears the sample bit
    wr(CFG_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0000_8002);
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      if (result_wr) n++;
    end
    chk(n, 0);
    wr(CTRL_OFS, 32'h0000_8000);
    to_result(n, p);
    chk(p, CONVERSION_IN_PROGRESS_TAD);
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      if (result_wr) n++;
    end
    chk(n, 0);
    wr(CTRL_OFS, 32'h0);
    wr(CFG_OFS, 32'h0011_0101);
    cpu_idle <= 1'b1;
    wr(CTRL_OFS, 32'h0000_80e4);
    n = 0;
    do begin
      @(posedge aclk);
      if (result_wr) n++;
    end while (!wake_req);
    chk(n, 2);
    cpu_idle <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    halt(1'b1);
    halt(1'b0);
    wr(CFG_OFS, 32'h0010_0081);
    wr(CTRL_OFS, 32'h0000_80e4);
    cpu_sleep <= 1'b1;
    n = 0;
    p = 0;
    do begin
      @(posedge aclk);
      if (result_wr) n++;
      if (sar_clk) p++;
    end while (!wake_req);
    chk(n, 1);
    chk(p, CONVERSION_IN_PROGRESS_TAD);
    cpu_sleep <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    wr(CFG_OFS, 32'h0000_0080);
    wr(CTRL_OFS, 32'h0000_80e4);
    cpu_sleep <= 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge aclk);
      if (result_wr) n++;
    end
    chk(n, 1);
    rd(STAT_OFS);
    chk(data[4:0], 5'h15);
    rd(CTRL_OFS);
    chk(data[15], 1'b1);
    cpu_sleep <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    close_out();
  end
endmodule : testbench
